// *** src/wgsr_pkg.sv ***
// Package for the wake, level and GPIO status register group
package wgsr_pkg;

	// Register addresses on the 7-bit serial address field
	localparam logic [6:0] ADDR_WAKE_A = 7'h46;
	localparam logic [6:0] ADDR_WAKE_B = 7'h47;
	localparam logic [6:0] ADDR_LEVEL = 7'h48;
	localparam logic [6:0] ADDR_GENERAL_PIN_OVERCURRENT = 7'h54;
	localparam logic [6:0] ADDR_GENERAL_PIN_OPEN_LOAD = 7'h55;

	// Field positions
	localparam int BIT_BUS_WAKE = 5;
	localparam int BIT_TIMER_WAKE = 4;
	localparam int BIT_HV_WAKE = 0;
	localparam int BIT_GPIO_WAKE = 4;
	localparam int BIT_DEV_LVL = 7;
	localparam int BIT_STRAP = 6;
	localparam int BIT_GENERAL_PIN_LEVEL = 4;
	localparam int BIT_HV_LVL = 0;
	localparam int BIT_GENERAL_PIN_OVERCURRENT = 6;
	localparam int BIT_GENERAL_PIN_OPEN_LOAD = 6;
	localparam int BIT_CAN_MODE_HI = 1;

	// Implemented-bit masks and the zero byte used for reserved and unmapped reads
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] MASK_WAKE_A = 8'h31;
	localparam logic [7:0] MASK_WAKE_B = 8'h10;
	localparam logic [7:0] MASK_LEVEL = 8'hd1;
	localparam logic [7:0] MASK_GENERAL_PIN_OVERCURRENT = 8'h40;
	localparam logic [7:0] MASK_GENERAL_PIN_OPEN_LOAD = 8'h40;

	// Asynchronous pins and their synchroniser depth
	localparam int NUM_PINS = 4;
	localparam int PIN_HV = 0;
	localparam int PIN_GPIO = 1;
	localparam int PIN_TEST = 2;
	localparam int PIN_STRAP = 3;
	localparam int SYNC_DEPTH = 3;

	// Operating modes, one-hot
	typedef enum logic [5:0] {
		WGSR_MODE_NORMAL = 6'h01,
		WGSR_MODE_STOP = 6'h02,
		WGSR_MODE_INIT = 6'h04,
		WGSR_MODE_RESTART = 6'h08,
		WGSR_MODE_SLEEP = 6'h10,
		WGSR_MODE_FAILSAFE = 6'h20
	} wgsr_mode_e;

	// General-purpose pin configurations, one-hot
	typedef enum logic [4:0] {
		WGSR_GPIO_OFF = 5'h01,
		WGSR_GPIO_FAIL_OUT = 5'h02,
		WGSR_GPIO_WAKE_IN = 5'h04,
		WGSR_GPIO_LOW_SIDE = 5'h08,
		WGSR_GPIO_HIGH_SIDE = 5'h10
	} wgsr_gpio_cfg_e;

	// Wake detection pulses from the wake logic
	typedef struct packed {
		logic bus;
		logic timer;
		logic hv;
		logic gpio;
	} wgsr_wake_s;

	// Register access request from the serial frame decoder
	typedef struct packed {
		logic [6:0] addr;
		logic clr;
	} wgsr_req_s;

endpackage : wgsr_pkg

// *** src/wgsr_status_regs.sv ***
// Wake source, pin level and GPIO fault status registers
// Overview of operation
// - Wake byte A latches bus wake bit5, timer bit4, HV pin bit0
// - Wake out of fail-safe still sets the causing source flag
// - Wake byte B bit4 set by GPIO wake when configured as wake input
// - Every reserved bit of these bytes reads as zero
// - Level byte bit7 shows test pin development mode
// - Level byte bit6 shows interrupt pin pull-up strap state
// - Level byte bit4 shows GPIO level in wake or switch use
// - Read-only level byte at 0x48, bit0 is HV wake pin level
// - Level byte refreshes in normal, stop, init and restart modes
// - Under cyclic sense or wake, the HV level loads at each sampling instant
// - GPIO level updates only without cyclic sense; fail output excluded
// - A disabled pin function freezes its level bit
// - HV measurement enabled clears and holds both level bits
// - Overcurrent bit6 covers both low-side and high-side switch use
// - Overcurrent flag stays until host clears it, despite reconfiguring
// - Open-load bit6 detected only in high-side switch configuration
// - Bus supply undervoltage comparator enabled when mode field bit1 is 1
// - Reset clears wake byte A; restart keeps its wake flags
// - Latched flags never clear when their cause goes away
`timescale 1ns/1ns
`default_nettype none

module wgsr_status_regs (
	input wire logic mclk,
	input wire logic srst,
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire wgsr_pkg::wgsr_mode_e op_mode,
	input wire wgsr_pkg::wgsr_gpio_cfg_e gpio_cfg,
	input wire logic hv_pin_enable,
	input wire logic hv_measure_enable,
	input wire logic cyclic_active,
	input wire logic cyclic_sample,
	input wire logic [1:0] can_mode,
	input wire wgsr_pkg::wgsr_wake_s wake_evt,
	input wire logic oc_detect,
	input wire logic ol_detect,
	input wire logic hv_wake_input,
	input wire logic gpio_pin,
	input wire logic test_pin,
	input wire logic interrupt_out_low,
	input wire wgsr_pkg::wgsr_req_s reg_req,
	output logic [7:0] reg_rd_data,
	output logic bus_supply_undervoltage_en,
	output logic fail_signal_output_event
);
	import wgsr_pkg::*;

	// Decode of a clear request aimed at one register
	function automatic logic clr_hit(input wgsr_req_s req,
		input logic [6:0] target);
		clr_hit = req.clr && (req.addr == target);
	endfunction : clr_hit

	logic [NUM_PINS-1:0] sync1_q, sync2_q, sync3_q;
	logic [NUM_PINS-1:0] pin_q;
	logic [NUM_PINS-1:0] pin_raw;
	logic bus_wake_flag_q;
	logic cyclic_timer_wake_flag_q;
	logic hv_pin_wake_flag_q;
	logic general_pin_wake_flag_q;
	logic general_pin_overcurrent_q;
	logic general_pin_open_load_q;
	logic hv_pin_level_q;
	logic general_pin_level_q;
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic uv_en_q;
	logic fo_event_q;
	logic gpio_prev_q;
	logic flag_reset, mode_refresh, hv_upd, gpio_upd;
	logic gpio_level_cfg, gpio_switch_cfg;
	logic [7:0] wake_a_byte, wake_b_byte, level_byte, oc_byte, ol_byte;

	assign pin_raw = {interrupt_out_low, test_pin, gpio_pin, hv_wake_input};

	// Three-stage synchronisers; the first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++)
		begin : g_sync
			always_ff @(posedge mclk)
			begin
				if (srst)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
				end
			end

			// A change counts only once stages two and three agree
			always_ff @(posedge mclk)
			begin
				if (srst)
					pin_q[gi] <= 1'b0;
				else if (sync2_q[gi] == sync3_q[gi])
					pin_q[gi] <= sync3_q[gi];
			end
		end
	endgenerate

	// Power-on or soft reset wipes every latched flag
	assign flag_reset = soft_reset;

	assign mode_refresh = (op_mode == WGSR_MODE_NORMAL) ||
		(op_mode == WGSR_MODE_STOP) || (op_mode == WGSR_MODE_INIT) ||
		(op_mode == WGSR_MODE_RESTART);

	assign gpio_switch_cfg = (gpio_cfg == WGSR_GPIO_LOW_SIDE) ||
		(gpio_cfg == WGSR_GPIO_HIGH_SIDE);
	assign gpio_level_cfg = gpio_switch_cfg || (gpio_cfg == WGSR_GPIO_WAKE_IN);

	assign hv_upd = mode_refresh && hv_pin_enable &&
		(!cyclic_active || cyclic_sample);

	// GPIO level only without cyclic sense
	assign gpio_upd = mode_refresh && gpio_level_cfg && !cyclic_active;

	// bus wake flag; event beats clear, reset beats both
	// set in any mode, fail-safe included
	always_ff @(posedge mclk)
	begin
		if (srst || flag_reset)
			bus_wake_flag_q <= 1'b0;
		else if (wake_evt.bus)
			bus_wake_flag_q <= 1'b1;
		else if (clr_hit(reg_req, ADDR_WAKE_A))
			bus_wake_flag_q <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (srst || flag_reset)
			cyclic_timer_wake_flag_q <= 1'b0;
		else if (wake_evt.timer)
			cyclic_timer_wake_flag_q <= 1'b1;
		else if (clr_hit(reg_req, ADDR_WAKE_A))
			cyclic_timer_wake_flag_q <= 1'b0;
	end

	// restart leaves wake byte A flags untouched
	always_ff @(posedge mclk)
	begin
		if (srst || flag_reset)
			hv_pin_wake_flag_q <= 1'b0;
		else if (wake_evt.hv)
			hv_pin_wake_flag_q <= 1'b1;
		else if (clr_hit(reg_req, ADDR_WAKE_A))
			hv_pin_wake_flag_q <= 1'b0;
	end

	// GPIO wake only while configured as wake input
	always_ff @(posedge mclk)
	begin
		if (srst || flag_reset || restart_entry)
			general_pin_wake_flag_q <= 1'b0;
		else if (wake_evt.gpio && (gpio_cfg == WGSR_GPIO_WAKE_IN))
			general_pin_wake_flag_q <= 1'b1;
		else if (clr_hit(reg_req, ADDR_WAKE_B))
			general_pin_wake_flag_q <= 1'b0;
	end

	// one overcurrent bit for either switch type
	// sticky across reconfiguration and restart; host clears it
	always_ff @(posedge mclk)
	begin
		if (srst || flag_reset)
			general_pin_overcurrent_q <= 1'b0;
		else if (oc_detect && gpio_switch_cfg)
			general_pin_overcurrent_q <= 1'b1;
		else if (clr_hit(reg_req, ADDR_GENERAL_PIN_OVERCURRENT))
			general_pin_overcurrent_q <= 1'b0;
	end

	// open load only in high-side use
	// no release when the condition goes away
	always_ff @(posedge mclk)
	begin
		if (srst || flag_reset)
			general_pin_open_load_q <= 1'b0;
		else if (ol_detect && (gpio_cfg == WGSR_GPIO_HIGH_SIDE))
			general_pin_open_load_q <= 1'b1;
		else if (clr_hit(reg_req, ADDR_GENERAL_PIN_OPEN_LOAD))
			general_pin_open_load_q <= 1'b0;
	end

	// measurement mode clears and holds it
	always_ff @(posedge mclk)
	begin
		if (srst || hv_measure_enable)
			hv_pin_level_q <= 1'b0;
		else if (hv_upd)
			hv_pin_level_q <= pin_q[PIN_HV];
	end

	// measurement mode clears and holds it
	always_ff @(posedge mclk)
	begin
		if (srst || hv_measure_enable)
			general_pin_level_q <= 1'b0;
		else if (gpio_upd)
			general_pin_level_q <= pin_q[PIN_GPIO];
	end

	// fail-output use reports pin changes as a failure event
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			gpio_prev_q <= 1'b0;
			fo_event_q <= 1'b0;
		end
		else
		begin
			gpio_prev_q <= pin_q[PIN_GPIO];
			fo_event_q <= (gpio_cfg == WGSR_GPIO_FAIL_OUT) &&
				(gpio_prev_q != pin_q[PIN_GPIO]);
		end
	end

	// comparator enable follows the mode field's upper bit
	always_ff @(posedge mclk)
	begin
		if (srst)
			uv_en_q <= 1'b0;
		else
			uv_en_q <= can_mode[BIT_CAN_MODE_HI];
	end

	// register images with reserved bits forced to zero
	always_comb
	begin
		wake_a_byte = BYTE_ZERO;
		wake_a_byte[BIT_BUS_WAKE] = bus_wake_flag_q;
		wake_a_byte[BIT_TIMER_WAKE] = cyclic_timer_wake_flag_q;
		wake_a_byte[BIT_HV_WAKE] = hv_pin_wake_flag_q;
		wake_b_byte = BYTE_ZERO;
		wake_b_byte[BIT_GPIO_WAKE] = general_pin_wake_flag_q;
		level_byte = BYTE_ZERO;
		// test pin and strap shown live
		level_byte[BIT_DEV_LVL] = pin_q[PIN_TEST];
		level_byte[BIT_STRAP] = pin_q[PIN_STRAP];
		level_byte[BIT_GENERAL_PIN_LEVEL] = general_pin_level_q;
		level_byte[BIT_HV_LVL] = hv_pin_level_q;
		oc_byte = BYTE_ZERO;
		oc_byte[BIT_GENERAL_PIN_OVERCURRENT] = general_pin_overcurrent_q;
		ol_byte = BYTE_ZERO;
		ol_byte[BIT_GENERAL_PIN_OPEN_LOAD] = general_pin_open_load_q;
	end

	// Read multiplexer; unmapped addresses return zero
	always_comb
	begin
		if (reg_req.addr == ADDR_WAKE_A)
			rd_data_d = wake_a_byte;
		else if (reg_req.addr == ADDR_WAKE_B)
			rd_data_d = wake_b_byte;
		else if (reg_req.addr == ADDR_LEVEL)
			rd_data_d = level_byte;
		else if (reg_req.addr == ADDR_GENERAL_PIN_OVERCURRENT)
			rd_data_d = oc_byte;
		else if (reg_req.addr == ADDR_GENERAL_PIN_OPEN_LOAD)
			rd_data_d = ol_byte;
		else
			rd_data_d = BYTE_ZERO;
	end

	// Read data registered so the frame shifter sees a stable byte
	// The byte shows the state before a same-cycle clear takes effect
	always_ff @(posedge mclk)
	begin
		if (srst)
			rd_data_q <= BYTE_ZERO;
		else
			rd_data_q <= rd_data_d;
	end

	assign reg_rd_data = rd_data_q;
	assign bus_supply_undervoltage_en = uv_en_q;
	assign fail_signal_output_event = fo_event_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	bus_wake_set_a: assert property (
		wake_evt.bus && !soft_reset |=> bus_wake_flag_q)
		else $error("bus wake event not latched");

	evt_beats_clr_a: assert property (
		oc_detect && gpio_switch_cfg && clr_hit(reg_req, ADDR_GENERAL_PIN_OVERCURRENT) &&
		!soft_reset |=> general_pin_overcurrent_q)
		else $error("overcurrent event lost to a same-cycle clear");

	failsafe_wake_a: assert property (
		op_mode == WGSR_MODE_FAILSAFE && wake_evt.hv && !soft_reset
		|=> hv_pin_wake_flag_q)
		else $error("fail-safe wake source not flagged");

	gpio_wake_a: assert property (
		$rose(general_pin_wake_flag_q)
		|-> $past(wake_evt.gpio) && $past(gpio_cfg) == WGSR_GPIO_WAKE_IN)
		else $error("gpio wake flag without wake-input event");

	reserved_zero_a: assert property (
		$past(reg_req.addr) == ADDR_LEVEL |-> (reg_rd_data & ~MASK_LEVEL)
		== BYTE_ZERO && (rd_data_d & ~(MASK_WAKE_A | MASK_WAKE_B |
		MASK_LEVEL | MASK_GENERAL_PIN_OVERCURRENT)) == BYTE_ZERO)
		else $error("reserved bit reads as one");

	dev_level_a: assert property (
		reg_req.addr == ADDR_LEVEL |=> reg_rd_data[BIT_DEV_LVL] ==
		$past(pin_q[PIN_TEST]))
		else $error("development mode level misreported");

	meas_clears_a: assert property (
		hv_measure_enable |=> !hv_pin_level_q && !general_pin_level_q)
		else $error("level bits not cleared under measurement");

	sleep_freeze_a: assert property (
		op_mode == WGSR_MODE_SLEEP && !hv_measure_enable
		|=> $stable(hv_pin_level_q) && $stable(general_pin_level_q))
		else $error("level bits changed outside refresh modes");

	cyclic_gpio_a: assert property (
		cyclic_active && !hv_measure_enable |=> $stable(general_pin_level_q))
		else $error("gpio level updated under cyclic sense");

	oc_sticky_a: assert property (
		general_pin_overcurrent_q && !clr_hit(reg_req, ADDR_GENERAL_PIN_OVERCURRENT) &&
		!soft_reset |=> general_pin_overcurrent_q)
		else $error("overcurrent flag dropped without clear");

	ol_hs_only_a: assert property (
		$rose(general_pin_open_load_q)
		|-> $past(gpio_cfg) == WGSR_GPIO_HIGH_SIDE)
		else $error("open load flagged outside high-side use");

	uv_enable_a: assert property (
		can_mode[BIT_CAN_MODE_HI] |=> bus_supply_undervoltage_en)
		else $error("undervoltage comparator not enabled");

	restart_keep_a: assert property (
		restart_entry && !soft_reset && bus_wake_flag_q &&
		!clr_hit(reg_req, ADDR_WAKE_A) |=> bus_wake_flag_q)
		else $error("restart cleared a wake flag");

endmodule : wgsr_status_regs

`default_nettype wire

// *** test/tb.sv ***
// Testbench for the wake, level and GPIO status register group
`timescale 1ns/1ns
`default_nettype none

module tb;
	import wgsr_pkg::*;

	typedef struct {
		wgsr_mode_e mode;
		wgsr_gpio_cfg_e cfg;
		logic [3:0] wk;
		logic oc;
		logic ol;
		logic [6:0] addr;
		logic [7:0] exp;
	} wgsr_row_s;

	logic mclk, srst, soft_reset, restart_entry, hv_pin_enable;
	logic hv_measure_enable, cyclic_active, cyclic_sample;
	logic oc_detect, ol_detect, hv_wake_input, gpio_pin, test_pin;
	logic interrupt_out_low, supply_uv_en, fail_evt;
	logic fail_seen = 1'b0;
	logic [1:0] can_mode;
	logic [7:0] reg_rd_data;
	wgsr_mode_e op_mode;
	wgsr_gpio_cfg_e gpio_cfg;
	wgsr_wake_s wake_evt;
	wgsr_req_s reg_req;
	int fail_count = 0;
	int samples_checked = 0;
	wgsr_row_s rows [10];

	wgsr_status_regs dut_u (.mclk(mclk), .srst(srst),
		.soft_reset(soft_reset), .restart_entry(restart_entry),
		.op_mode(op_mode), .gpio_cfg(gpio_cfg),
		.hv_pin_enable(hv_pin_enable),
		.hv_measure_enable(hv_measure_enable),
		.cyclic_active(cyclic_active), .cyclic_sample(cyclic_sample),
		.can_mode(can_mode), .wake_evt(wake_evt), .oc_detect(oc_detect),
		.ol_detect(ol_detect), .hv_wake_input(hv_wake_input),
		.gpio_pin(gpio_pin), .test_pin(test_pin),
		.interrupt_out_low(interrupt_out_low), .reg_req(reg_req),
		.reg_rd_data(reg_rd_data),
		.bus_supply_undervoltage_en(supply_uv_en),
		.fail_signal_output_event(fail_evt));

	wgsr_host_model host_u (.mclk(mclk), .reg_req(reg_req),
		.reg_rd_data(reg_rd_data));

	// 125 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Fail-output pulse is one cycle wide, so it is caught here
	always @(posedge mclk)
		if (fail_evt === 1'b1)
			fail_seen <= 1'b1;

	task automatic stop_test;
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.access(a, 1'b0, d);
		chk($sformatf("reg_%h", a), d, e);
	endtask : rd

	task automatic clr(input logic [6:0] a);
		logic [7:0] d;
		host_u.access(a, 1'b1, d);
	endtask : clr

	// Detection pulses last one cycle, as the wake logic gives them
	task automatic fire(input logic [3:0] wk, input logic oc,
		input logic ol);
		wake_evt = wgsr_wake_s'(wk);
		oc_detect = oc;
		ol_detect = ol;
		cyc(1);
		wake_evt = '0;
		oc_detect = 1'b0;
		ol_detect = 1'b0;
	endtask : fire

	// Wake, overcurrent and open-load cases: event, read, clear, read
	initial
	begin
		rows[0] = '{WGSR_MODE_FAILSAFE, WGSR_GPIO_OFF, 4'ha, 0, 0,
			ADDR_WAKE_A, 8'h21};
		rows[1] = '{WGSR_MODE_NORMAL, WGSR_GPIO_OFF, 4'h4, 0, 0,
			ADDR_WAKE_A, 8'h10};
		rows[2] = '{WGSR_MODE_NORMAL, WGSR_GPIO_OFF, 4'h2, 0, 0,
			ADDR_WAKE_A, 8'h01};
		rows[3] = '{WGSR_MODE_NORMAL, WGSR_GPIO_OFF, 4'he, 0, 0,
			ADDR_WAKE_A, 8'h31};
		rows[4] = '{WGSR_MODE_NORMAL, WGSR_GPIO_WAKE_IN, 4'h1, 0, 0,
			ADDR_WAKE_B, 8'h10};
		rows[5] = '{WGSR_MODE_NORMAL, WGSR_GPIO_LOW_SIDE, 4'h1, 0, 0,
			ADDR_WAKE_B, 8'h00};
		rows[6] = '{WGSR_MODE_NORMAL, WGSR_GPIO_LOW_SIDE, 4'h0, 1, 0,
			ADDR_GENERAL_PIN_OVERCURRENT, 8'h40};
		rows[7] = '{WGSR_MODE_NORMAL, WGSR_GPIO_HIGH_SIDE, 4'h0, 1, 0,
			ADDR_GENERAL_PIN_OVERCURRENT, 8'h40};
		rows[8] = '{WGSR_MODE_NORMAL, WGSR_GPIO_HIGH_SIDE, 4'h0, 0, 1,
			ADDR_GENERAL_PIN_OPEN_LOAD, 8'h40};
		rows[9] = '{WGSR_MODE_NORMAL, WGSR_GPIO_LOW_SIDE, 4'h0, 0, 1,
			ADDR_GENERAL_PIN_OPEN_LOAD, 8'h00};
		{srst, soft_reset, restart_entry, hv_measure_enable} = '0;
		{cyclic_active, cyclic_sample, can_mode, oc_detect} = '0;
		{ol_detect, hv_wake_input, gpio_pin, test_pin} = '0;
		interrupt_out_low = 1'b0;
		wake_evt = '0;
		hv_pin_enable = 1'b1;
		op_mode = WGSR_MODE_NORMAL;
		gpio_cfg = WGSR_GPIO_WAKE_IN;
		srst = 1'b1;
		cyc(6);
		srst = 1'b0;
		cyc(6);
		rd(ADDR_WAKE_A, 8'h00);
		rd(ADDR_LEVEL, 8'h00);
		rd(7'h00, 8'h00);
		foreach (rows[i])
		begin
			op_mode = rows[i].mode;
			gpio_cfg = rows[i].cfg;
			cyc(1);
			fire(rows[i].wk, rows[i].oc, rows[i].ol);
			rd(rows[i].addr, rows[i].exp);
			clr(rows[i].addr);
			rd(rows[i].addr, 8'h00);
		end
		// Level byte: live pins, measurement, mode and function gating
		op_mode = WGSR_MODE_NORMAL;
		gpio_cfg = WGSR_GPIO_WAKE_IN;
		{test_pin, interrupt_out_low, hv_wake_input, gpio_pin} = 4'hf;
		cyc(8);
		rd(ADDR_LEVEL, 8'hd1);
		hv_measure_enable = 1'b1;
		cyc(2);
		rd(ADDR_LEVEL, 8'hc0);
		hv_measure_enable = 1'b0;
		cyc(2);
		rd(ADDR_LEVEL, 8'hd1);
		op_mode = WGSR_MODE_SLEEP;
		{hv_wake_input, gpio_pin} = 2'b00;
		cyc(8);
		rd(ADDR_LEVEL, 8'hd1);
		op_mode = WGSR_MODE_NORMAL;
		cyc(2);
		rd(ADDR_LEVEL, 8'hc0);
		chk("fail_evt", {7'h00, fail_seen}, 8'h00);
		hv_pin_enable = 1'b0;
		gpio_cfg = WGSR_GPIO_FAIL_OUT;
		{hv_wake_input, gpio_pin} = 2'b11;
		cyc(8);
		rd(ADDR_LEVEL, 8'hc0);
		chk("fail_evt", {7'h00, fail_seen}, 8'h01);
		// Cyclic mode loads the HV level only at the sampling instant; GPIO level holds
		hv_pin_enable = 1'b1;
		gpio_cfg = WGSR_GPIO_WAKE_IN;
		cyclic_active = 1'b1;
		cyc(3);
		rd(ADDR_LEVEL, 8'hc0);
		cyclic_sample = 1'b1;
		cyc(1);
		cyclic_sample = 1'b0;
		cyc(1);
		rd(ADDR_LEVEL, 8'hc1);
		cyclic_active = 1'b0;
		// Overcurrent survives reconfiguring; event beats a clear
		gpio_cfg = WGSR_GPIO_LOW_SIDE;
		fire(4'h0, 1'b1, 1'b0);
		gpio_cfg = WGSR_GPIO_OFF;
		cyc(4);
		rd(ADDR_GENERAL_PIN_OVERCURRENT, 8'h40);
		gpio_cfg = WGSR_GPIO_LOW_SIDE;
		fork
			fire(4'h0, 1'b1, 1'b0);
			clr(ADDR_GENERAL_PIN_OVERCURRENT);
		join
		rd(ADDR_GENERAL_PIN_OVERCURRENT, 8'h40);
		clr(ADDR_GENERAL_PIN_OVERCURRENT);
		rd(ADDR_GENERAL_PIN_OVERCURRENT, 8'h00);
		// Restart keeps wake byte A and overcurrent, clears wake byte B; soft reset clears both
		gpio_cfg = WGSR_GPIO_WAKE_IN;
		fire(4'h9, 1'b0, 1'b0);
		gpio_cfg = WGSR_GPIO_LOW_SIDE;
		fire(4'h0, 1'b1, 1'b0);
		restart_entry = 1'b1;
		cyc(1);
		restart_entry = 1'b0;
		rd(ADDR_WAKE_A, 8'h20);
		rd(ADDR_WAKE_B, 8'h00);
		rd(ADDR_GENERAL_PIN_OVERCURRENT, 8'h40);
		soft_reset = 1'b1;
		cyc(1);
		soft_reset = 1'b0;
		rd(ADDR_WAKE_A, 8'h00);
		rd(ADDR_GENERAL_PIN_OVERCURRENT, 8'h00);
		// Comparator enable follows the upper mode bit
		for (int m = 0; m < 4; m++)
		begin
			can_mode = 2'(m);
			cyc(2);
			chk("uv_en", {7'h00, supply_uv_en}, {7'h00, can_mode[1]});
		end
		stop_test();
	end

	// Guard against a hung run
	initial
	begin
		#200000;
		fail_count++;
		stop_test();
	end
endmodule : tb
`default_nettype wire

// *** test/wgsr_host_model.sv ***
// Host-side model issuing register reads and clears
`timescale 1ns/1ns
`default_nettype none

module wgsr_host_model (
	input wire logic mclk,
	output var wgsr_pkg::wgsr_req_s reg_req,
	input wire logic [7:0] reg_rd_data
);
	import wgsr_pkg::*;

	// Idle request at time zero
	initial reg_req = '0;

	// One access, entered at a falling edge; address held until the byte
	// is taken, so a read paired with a clear shows the pre-clear value
	// host clear
	task automatic access(input logic [6:0] a, input logic c,
		output logic [7:0] d);
		reg_req.addr = a;
		if (c)
			reg_req.clr = 1'b1;
		@(negedge mclk);
		d = reg_rd_data;
		// Release the clear and let an edge pass, so a following call
		// never drives the strobe twice in one time step
		if (c)
		begin
			reg_req.clr = 1'b0;
			@(negedge mclk);
		end
	endtask : access
endmodule : wgsr_host_model
`default_nettype wire
